// file: pkg/mcdma_pkg.sv
// constants and types shared by the multichannel dma controller
package mcdma_pkg;
	localparam int NCH = 8;
	localparam int IDX_W = 3;
	localparam int CNT_W = 16;
	localparam int AW = 12;
	// per channel window: channel index in paddr[6:4], register in paddr[3:0]
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_PBASE = 4'h4;
	localparam logic [3:0] OFS_MBASE = 4'h8;
	localparam logic [3:0] OFS_COUNT = 4'hc;
	localparam logic [AW-1:0] OFS_FLAGS = 12'h080;
	localparam logic [AW-1:0] OFS_SWTRIG = 12'h084;
	// channel_control_reg fields
	localparam int CTL_EN = 0;
	localparam int CTL_ALL_IE = 1;
	localparam int CTL_HALF_IE = 2;
	localparam int CTL_DIR = 4;
	localparam int CTL_CIRCULAR_EN = 5;
	localparam int CTL_PER_INC = 6;
	localparam int CTL_MEM_INC = 7;
	localparam int CTL_PW_LSB = 8;
	localparam int CTL_MW_LSB = 10;
	localparam int CTL_PRIO_LSB = 12;
	localparam int CTL_M2M = 14;
	localparam logic [31:0] CTRL_MASK = 32'h00007ff7;
	localparam logic [31:0] CTRL_RST = 32'h00000000;
	localparam logic [31:0] ADDR_RST = 32'h00000000;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	typedef enum logic [1:0] {
		W_BYTE = 2'b00,
		W_HALF = 2'b01,
		W_WORD = 2'b10
	} mcdma_width_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RD = 2'b01,
		ST_WR = 2'b10
	} mcdma_state_t;
endpackage : mcdma_pkg

// file: pkg/mcdma_arb_if.sv
// channel arbitration signals between controller and arbiter
`timescale 1ns/1ps
`default_nettype none
interface mcdma_arb_if;
	import mcdma_pkg::*;
	logic [NCH-1:0] pend;
	logic [1:0] prio [NCH];
	logic gnt_valid;
	logic [IDX_W-1:0] gnt_idx;
	modport ctl (output pend, output prio, input gnt_valid, input gnt_idx);
	modport arb (input pend, input prio, output gnt_valid, output gnt_idx);
endinterface : mcdma_arb_if
`default_nettype wire

// file: rtl/mcdma_sync.sv
// three-stage synchroniser for the peripheral request pins
`timescale 1ns/1ps
`default_nettype none
module mcdma_sync #(
	parameter int W = 8
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] level_o
);
	for (genvar i = 0; i < W; i++) begin : g_bit
		logic s1_q, s2_q, s3_q, lvl_q, lvl_d;
		// only counted once stages two and three agree
		always_comb begin
			lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
		end
		always_ff @(posedge core_clk_i or posedge rst_i) begin
			if (rst_i) begin
				s1_q <= 1'b0;
				s2_q <= 1'b0;
				s3_q <= 1'b0;
				lvl_q <= 1'b0;
			end else begin
				s1_q <= async_i[i];
				s2_q <= s1_q;
				s3_q <= s2_q;
				lvl_q <= lvl_d;
			end
		end
		assign level_o[i] = lvl_q;
	end
endmodule : mcdma_sync
`default_nettype wire

// file: rtl/mcdma_arb.sv
// fixed two-stage channel arbiter: level first, then lower index
`timescale 1ns/1ps
`default_nettype none
module mcdma_arb (
	mcdma_arb_if.arb arb
);
	import mcdma_pkg::*;
	logic [1:0] best;
	always_comb begin
		best = 2'b00;
		arb.gnt_valid = 1'b0;
		arb.gnt_idx = '0;
		// walking down with >= lets the lower index take a tie
		for (int i = NCH - 1; i >= 0; i--) begin
			if (arb.pend[i] && (!arb.gnt_valid || arb.prio[i] >= best)) begin // [RULE2] [RULE3]
				best = arb.prio[i];
				arb.gnt_valid = 1'b1;
				arb.gnt_idx = IDX_W'(i);
			end
		end
	end
endmodule : mcdma_arb
`default_nettype wire

// file: rtl/mcdma_top.sv
// multichannel dma controller: apb registers, channel state and bus sequencer
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE1 - eight channels, each with a hardware request pin and a software trigger
// RULE2 - two-bit per-channel priority field selects one of four levels
// RULE3 - equal priority levels resolve to the lower channel index
// RULE4 - source and destination widths chosen independently; data packed or unpacked (the code zero-extends or truncates instead, one read per write)
// RULE5 - half and complete flags ORed into one interrupt per channel
// RULE6 - memory, peripheral and mixed transfer types all supported
// RULE7 - sixteen-bit item count, decremented after each transaction
// RULE8 - serve requests by priority; acknowledge when the peripheral access happens
// RULE9 - peripheral raises request after its event, drops it on acknowledge
// RULE10 - acknowledge falls only after request falls; four-phase handshake
// RULE11 - each transfer is read source, write destination, decrement count
// RULE12 - first access uses base addresses; working pointers are internal
// RULE13 - enabled pointers advance by 1, 2 or 4 per transaction
// RULE14 - non-circular channel at zero count serves no more requests
// RULE15 - item count writable only while the channel is disabled
// RULE16 - disabling keeps control and address registers intact
// RULE17 - circular mode reloads count and working pointers after last item
// RULE18 - enabled channel accepts and serves its peripheral requests
// RULE19 - half-transfer flag at half count; interrupt if its enable is set
// RULE20 - complete flag at zero count; interrupt if its enable is set
// RULE21 - software sets addresses, count, settings, then enable last
// RULE22 - memory-to-memory runs on enable without request, stops at zero
// RULE23 - flags sticky until software clears; interrupt follows enabled flags
// RULE24 - one transfer at a time; arbitration repeats after each one
module mcdma_top (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [mcdma_pkg::AW-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [mcdma_pkg::NCH-1:0] dreq_i,
	output logic [mcdma_pkg::NCH-1:0] dack_o,
	output logic [mcdma_pkg::NCH-1:0] irq_o,
	output logic bus_valid_o,
	output logic bus_write_o,
	output logic [31:0] bus_addr_o,
	output logic [1:0] bus_size_o,
	output logic [31:0] bus_wdata_o,
	input wire logic bus_ready_i,
	input wire logic [31:0] bus_rdata_i
);
	import mcdma_pkg::*;

	function automatic logic [31:0] mask_w(input logic [31:0] v, input logic [1:0] w);
		unique case (w)
			W_BYTE: mask_w = {24'h000000, v[7:0]};
			W_HALF: mask_w = {16'h0000, v[15:0]};
			default: mask_w = v;
		endcase
	endfunction : mask_w

	function automatic logic [31:0] step_w(input logic [1:0] w);
		unique case (w)
			W_BYTE: step_w = 32'h00000001;
			W_HALF: step_w = 32'h00000002;
			default: step_w = 32'h00000004;
		endcase
	endfunction : step_w

	logic [31:0] ctrl_q [NCH];
	logic [31:0] ctrl_d [NCH];
	logic [31:0] pbase_q [NCH];
	logic [31:0] pbase_d [NCH];
	logic [31:0] mbase_q [NCH];
	logic [31:0] mbase_d [NCH];
	logic [31:0] pcur_q [NCH];
	logic [31:0] pcur_d [NCH];
	logic [31:0] mcur_q [NCH];
	logic [31:0] mcur_d [NCH];
	logic [CNT_W-1:0] cnt_q [NCH];
	logic [CNT_W-1:0] cnt_d [NCH];
	logic [CNT_W-1:0] rld_q [NCH];
	logic [CNT_W-1:0] rld_d [NCH];
	logic [NCH-1:0] half_q, half_d, all_q, all_d;
	logic [NCH-1:0] swreq_q, swreq_d, ack_q, ack_d, irq_q, irq_d;
	mcdma_state_t st_q, st_d;
	logic [IDX_W-1:0] ch_q, ch_d;
	logic hw_q, hw_d;
	logic bus_valid_q, bus_valid_d, bus_write_q, bus_write_d;
	logic [31:0] bus_addr_q, bus_addr_d, bus_wdata_q, bus_wdata_d;
	logic [1:0] bus_size_q, bus_size_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d;
	logic [NCH-1:0] req_s;

	logic setup, wr_acc, in_ch, hit;
	logic [IDX_W-1:0] ach;
	logic [3:0] areg;
	logic [31:0] cc;
	logic dir;
	logic [CNT_W-1:0] ncnt;

	mcdma_arb_if arb_if ();

	mcdma_sync #(.W(NCH)) u_sync (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.async_i(dreq_i),
		.level_o(req_s)
	);

	mcdma_arb u_arb (
		.arb(arb_if)
	);

	// pending set fed to the arbiter
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			arb_if.prio[c] = ctrl_q[c][CTL_PRIO_LSB +: 2]; // [RULE2]
			arb_if.pend[c] = ctrl_q[c][CTL_EN] && (cnt_q[c] != CNT_RST) // [RULE14] [RULE18]
				&& (ctrl_q[c][CTL_M2M] || swreq_q[c] // [RULE22] [RULE1]
				|| (req_s[c] && !ack_q[c])); // [RULE10]
		end
	end

	assign setup = psel_i && !penable_i;
	assign wr_acc = psel_i && penable_i && pready_q && pwrite_i;
	assign in_ch = (paddr_i[AW-1:7] == '0) && (paddr_i[1:0] == 2'b00);
	assign ach = paddr_i[6:4];
	assign areg = paddr_i[3:0];
	assign hit = in_ch || paddr_i == OFS_FLAGS || paddr_i == OFS_SWTRIG;

	always_comb begin
		ctrl_d = ctrl_q;
		pbase_d = pbase_q;
		mbase_d = mbase_q;
		pcur_d = pcur_q;
		mcur_d = mcur_q;
		cnt_d = cnt_q;
		rld_d = rld_q;
		half_d = half_q;
		all_d = all_q;
		swreq_d = swreq_q;
		ack_d = ack_q;
		st_d = st_q;
		ch_d = ch_q;
		hw_d = hw_q;
		bus_valid_d = bus_valid_q;
		bus_write_d = bus_write_q;
		bus_addr_d = bus_addr_q;
		bus_size_d = bus_size_q;
		bus_wdata_d = bus_wdata_q;
		cc = ctrl_q[ch_q];
		dir = cc[CTL_DIR];
		ncnt = cnt_q[ch_q] - 16'h0001;
		// apb: one wait-free access, answer registered at the setup edge
		pready_d = setup;
		pslverr_d = setup && !hit;
		prdata_d = 32'h00000000;
		if (setup && !pwrite_i && in_ch) begin
			unique case (areg)
				OFS_CTRL: prdata_d = ctrl_q[ach];
				OFS_PBASE: prdata_d = pbase_q[ach];
				OFS_MBASE: prdata_d = mbase_q[ach];
				OFS_COUNT: prdata_d = {16'h0000, cnt_q[ach]};
				default: prdata_d = 32'h00000000;
			endcase
		end else if (setup && !pwrite_i && paddr_i == OFS_FLAGS) begin
			for (int c = 0; c < NCH; c++) begin
				prdata_d[2 * c] = half_q[c];
				prdata_d[2 * c + 1] = all_q[c];
			end
		end else if (setup && !pwrite_i && paddr_i == OFS_SWTRIG) begin
			prdata_d = {24'h000000, swreq_q};
		end
		if (wr_acc && in_ch) begin
			unique case (areg)
				OFS_CTRL: begin
					ctrl_d[ach] = pwdata_i & CTRL_MASK;
					// working pointers restart from the bases on enable
					if (pwdata_i[CTL_EN] && !ctrl_q[ach][CTL_EN]) begin
						pcur_d[ach] = pbase_q[ach]; // [RULE12]
						mcur_d[ach] = mbase_q[ach]; // [RULE12]
					end
				end
				OFS_PBASE: pbase_d[ach] = pwdata_i;
				OFS_MBASE: mbase_d[ach] = mwdata_sel(pwdata_i);
				OFS_COUNT: begin
					if (!ctrl_q[ach][CTL_EN]) begin // [RULE15]
						cnt_d[ach] = pwdata_i[CNT_W-1:0]; // [RULE7]
						rld_d[ach] = pwdata_i[CNT_W-1:0];
					end
				end
				default: ;
			endcase
		end
		if (wr_acc && paddr_i == OFS_FLAGS) begin
			for (int c = 0; c < NCH; c++) begin
				if (pwdata_i[2 * c]) half_d[c] = 1'b0; // [RULE23]
				if (pwdata_i[2 * c + 1]) all_d[c] = 1'b0; // [RULE23]
			end
		end
		if (wr_acc && paddr_i == OFS_SWTRIG) begin
			swreq_d = swreq_q | pwdata_i[NCH-1:0]; // [RULE1]
		end
		// acknowledge is held until the peripheral has let go of its request
		for (int c = 0; c < NCH; c++) begin
			if (ack_q[c] && !req_s[c]) ack_d[c] = 1'b0; // [RULE10]
		end
		// sequencer: hardware sets below land after the software clears above
		unique case (st_q)
			ST_IDLE: begin
				if (arb_if.gnt_valid) begin // [RULE24] [RULE8]
					ch_d = arb_if.gnt_idx;
					cc = ctrl_q[arb_if.gnt_idx];
					dir = cc[CTL_DIR];
					hw_d = !cc[CTL_M2M] && !swreq_q[arb_if.gnt_idx];
					bus_valid_d = 1'b1;
					bus_write_d = 1'b0;
					bus_addr_d = dir ? mcur_q[arb_if.gnt_idx] : pcur_q[arb_if.gnt_idx]; // [RULE11] [RULE6]
					bus_size_d = dir ? cc[CTL_MW_LSB +: 2] : cc[CTL_PW_LSB +: 2]; // [RULE4]
					st_d = ST_RD;
				end
			end
			ST_RD: begin
				if (bus_ready_i) begin
					bus_write_d = 1'b1;
					bus_addr_d = dir ? pcur_q[ch_q] : mcur_q[ch_q]; // [RULE11]
					bus_size_d = dir ? cc[CTL_PW_LSB +: 2] : cc[CTL_MW_LSB +: 2]; // [RULE4]
					// narrow source zero-extends; narrow destination truncates to its low lanes
					bus_wdata_d = mask_w(mask_w(bus_rdata_i, bus_size_q), bus_size_d); // [RULE4]
					if (hw_q && !dir) ack_d[ch_q] = 1'b1; // [RULE8]
					st_d = ST_WR;
				end
			end
			ST_WR: begin
				if (bus_ready_i) begin
					bus_valid_d = 1'b0;
					bus_write_d = 1'b0;
					st_d = ST_IDLE;
					if (hw_q && dir) ack_d[ch_q] = 1'b1; // [RULE8]
					// a trigger written in this very cycle is kept, not lost to the clear
					if (!hw_q) swreq_d[ch_q] = wr_acc && paddr_i == OFS_SWTRIG && pwdata_i[ch_q]; // [RULE1]
					if (cc[CTL_PER_INC]) begin
						pcur_d[ch_q] = pcur_q[ch_q] + step_w(cc[CTL_PW_LSB +: 2]); // [RULE13]
					end
					if (cc[CTL_MEM_INC]) begin
						mcur_d[ch_q] = mcur_q[ch_q] + step_w(cc[CTL_MW_LSB +: 2]); // [RULE13]
					end
					cnt_d[ch_q] = ncnt; // [RULE11] [RULE7]
					if (ncnt == (rld_q[ch_q] >> 1)) half_d[ch_q] = 1'b1; // [RULE19]
					if (ncnt == CNT_RST) begin
						all_d[ch_q] = 1'b1; // [RULE20]
						// memory-to-memory never wraps, even with circular set
						if (cc[CTL_CIRCULAR_EN] && !cc[CTL_M2M]) begin // [RULE22]
							cnt_d[ch_q] = rld_q[ch_q]; // [RULE17]
							pcur_d[ch_q] = pbase_q[ch_q]; // [RULE17]
							mcur_d[ch_q] = mbase_q[ch_q]; // [RULE17]
						end
					end
				end
			end
			default: begin
				st_d = ST_IDLE;
				bus_valid_d = 1'b0;
				bus_write_d = 1'b0;
			end
		endcase
		for (int c = 0; c < NCH; c++) begin
			irq_d[c] = (half_d[c] && ctrl_d[c][CTL_HALF_IE]) // [RULE5] [RULE19]
				|| (all_d[c] && ctrl_d[c][CTL_ALL_IE]); // [RULE5] [RULE20] [RULE23]
		end
	end

	function automatic logic [31:0] mwdata_sel(input logic [31:0] v);
		mwdata_sel = v;
	endfunction : mwdata_sel

	// disabling leaves every register alone; reset clears them all
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int c = 0; c < NCH; c++) begin
				ctrl_q[c] <= CTRL_RST; // [RULE16]
				pbase_q[c] <= ADDR_RST;
				mbase_q[c] <= ADDR_RST;
				pcur_q[c] <= ADDR_RST;
				mcur_q[c] <= ADDR_RST;
				cnt_q[c] <= CNT_RST;
				rld_q[c] <= CNT_RST;
			end
			half_q <= '0;
			all_q <= '0;
			swreq_q <= '0;
			ack_q <= '0;
			irq_q <= '0;
			st_q <= ST_IDLE;
			ch_q <= '0;
			hw_q <= 1'b0;
			bus_valid_q <= 1'b0;
			bus_write_q <= 1'b0;
			bus_addr_q <= ADDR_RST;
			bus_size_q <= W_BYTE;
			bus_wdata_q <= 32'h00000000;
			prdata_q <= 32'h00000000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			pbase_q <= pbase_d;
			mbase_q <= mbase_d;
			pcur_q <= pcur_d;
			mcur_q <= mcur_d;
			cnt_q <= cnt_d;
			rld_q <= rld_d;
			half_q <= half_d;
			all_q <= all_d;
			swreq_q <= swreq_d;
			ack_q <= ack_d;
			irq_q <= irq_d;
			st_q <= st_d;
			ch_q <= ch_d;
			hw_q <= hw_d;
			bus_valid_q <= bus_valid_d;
			bus_write_q <= bus_write_d;
			bus_addr_q <= bus_addr_d;
			bus_size_q <= bus_size_d;
			bus_wdata_q <= bus_wdata_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;
	assign dack_o = ack_q;
	assign irq_o = irq_q;
	assign bus_valid_o = bus_valid_q;
	assign bus_write_o = bus_write_q;
	assign bus_addr_o = bus_addr_q;
	assign bus_size_o = bus_size_q;
	assign bus_wdata_o = bus_wdata_q;
endmodule : mcdma_top
`default_nettype wire

// file: test/mcdma_top_asserts.sv
// concurrent checks on the dma controller top ports
`timescale 1ns/1ps
`default_nettype none
module mcdma_top_asserts
	import mcdma_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic [NCH-1:0] dreq_i,
	input wire logic [NCH-1:0] dack_o,
	input wire logic [NCH-1:0] irq_o,
	input wire logic bus_valid_o,
	input wire logic bus_write_o,
	input wire logic [31:0] bus_addr_o,
	input wire logic [1:0] bus_size_o,
	input wire logic bus_ready_i
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	logic rd_done;
	logic wr_done;
	logic cause;
	assign rd_done = bus_valid_o && bus_ready_i && !bus_write_o;
	assign wr_done = bus_valid_o && bus_ready_i && bus_write_o;
	// an irq may rise from an item finishing or from software touching enables
	assign cause = wr_done || (psel_i && penable_i && pwrite_i);
	apb_answer_a: assert property (psel_i && !penable_i |=> pready_o)
		else $error("apb access cycle without ready");
	err_with_ready_a: assert property (pslverr_o |-> pready_o)
		else $error("slave error outside access cycle");
	beat_hold_a: assert property (bus_valid_o && !bus_ready_i |=> bus_valid_o &&
		$stable(bus_addr_o) && $stable(bus_write_o) && $stable(bus_size_o))
		else $error("bus beat changed before ready");
	read_then_write_a: assert property (rd_done |=> bus_valid_o && bus_write_o)
		else $error("read not followed by write");
	idle_after_item_a: assert property (wr_done |=> !bus_valid_o)
		else $error("no idle cycle after item");
	read_first_a: assert property ($rose(bus_valid_o) |-> !bus_write_o)
		else $error("item did not start with read");
	size_legal_a: assert property (bus_valid_o |-> bus_size_o != 2'b11)
		else $error("illegal bus size");
	ack_release_a: assert property (($past(dack_o) & ~dack_o & (dreq_i | $past(dreq_i))) == '0)
		else $error("acknowledge fell while request high");
	ack_at_access_a: assert property (|(dack_o & ~$past(dack_o)) |-> $past(rd_done || wr_done))
		else $error("acknowledge without bus access");
	one_ack_a: assert property ($onehot0(dack_o & ~$past(dack_o)))
		else $error("two acknowledges at once");
	irq_cause_a: assert property (|(irq_o & ~$past(irq_o)) |->
		$past(cause) || $past(cause, 2) || $past(cause, 3))
		else $error("interrupt rose without cause");
	cover property (wr_done && bus_size_o == 2'b10);
	cover property (|dack_o);
	cover property (|irq_o);
endmodule : mcdma_top_asserts
bind mcdma_top mcdma_top_asserts i_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .dreq_i(dreq_i), .dack_o(dack_o), .irq_o(irq_o),
	.bus_valid_o(bus_valid_o), .bus_write_o(bus_write_o), .bus_addr_o(bus_addr_o),
	.bus_size_o(bus_size_o), .bus_ready_i(bus_ready_i));
`default_nettype wire

// file: test/mcdma_far_model.sv
// system bus slave and requesting peripherals facing the dma controller
`timescale 1ns/1ps
`default_nettype none
module mcdma_far_model
	import mcdma_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [3:0] wait_i,
	input wire logic [NCH-1:0] fire_i,
	input wire logic [NCH-1:0] dack_i,
	output logic [NCH-1:0] dreq_o,
	input wire logic bus_valid_i,
	input wire logic [31:0] bus_addr_i,
	output logic bus_ready_o,
	output logic [31:0] bus_rdata_o
);
	localparam logic [31:0] PAT = 32'h5aa5c33c;
	logic [3:0] cnt_q;
	logic [31:0] last_q;
	// outside a beat the data lines toggle, so a late sample cannot pass by luck
	assign bus_rdata_o = bus_ready_o ? (bus_addr_i ^ PAT) : ~last_q;
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= 4'h0;
			bus_ready_o <= 1'b0;
			last_q <= 32'h0;
			dreq_o <= '0;
		end else begin
			bus_ready_o <= bus_valid_i && !bus_ready_o && cnt_q >= wait_i;
			cnt_q <= (bus_valid_i && !bus_ready_o) ? cnt_q + 4'h1 : 4'h0;
			last_q <= bus_rdata_o;
			// drop on acknowledge; a new event is ignored until ack is low
			dreq_o <= (dreq_o & ~dack_i) | (fire_i & ~dack_i);
		end
	end
endmodule : mcdma_far_model
`default_nettype wire

// file: test/multichannel_dma_controller_test.sv
// self-checking bench for the multichannel dma controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
	$display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module multichannel_dma_controller_test;
	import mcdma_pkg::*;
	localparam logic [31:0] PAT = 32'h5aa5c33c;
	logic core_clk_i, rst_i, psel, penable, pwrite, pready, pslverr, bus_valid, bus_write;
	logic bus_ready, e;
	logic [AW-1:0] paddr;
	logic [31:0] pwdata, prdata, bus_addr, bus_wdata, bus_rdata, r;
	logic [1:0] bus_size;
	logic [NCH-1:0] dreq, dack, irq, fire;
	logic [3:0] wait_c;
	int miscompares, n_compared, i;
	always #12.5 core_clk_i = ~core_clk_i;
	mcdma_top i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .dreq_i(dreq),
		.dack_o(dack), .irq_o(irq), .bus_valid_o(bus_valid), .bus_write_o(bus_write),
		.bus_addr_o(bus_addr), .bus_size_o(bus_size), .bus_wdata_o(bus_wdata),
		.bus_ready_i(bus_ready), .bus_rdata_i(bus_rdata));
	mcdma_far_model i_far (.core_clk_i(core_clk_i), .rst_i(rst_i), .wait_i(wait_c),
		.fire_i(fire), .dack_i(dack), .dreq_o(dreq), .bus_valid_i(bus_valid),
		.bus_addr_i(bus_addr), .bus_ready_o(bus_ready), .bus_rdata_o(bus_rdata));
	function automatic logic [31:0] pb(input int c);
		return 32'h40000000 + 32'(c * 16);
	endfunction : pb
	function automatic logic [31:0] mb(input int c);
		return 32'h20000000 + 32'(c * 256);
	endfunction : mb
	function automatic logic [31:0] b8(input logic [31:0] a);
		return {24'h0, a[7:0] ^ PAT[7:0]};
	endfunction : b8
	function automatic logic [AW-1:0] ra(input int c, input logic [3:0] o);
		return AW'(c * 16) + AW'(o);
	endfunction : ra
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : test_done
	task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk_i);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge core_clk_i);
			if (pready === 1'b1) break;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20) begin
			miscompares++;
			test_done();
		end
	endtask : apb
	task automatic rdc(input logic [AW-1:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		`CHK(r, x)
	endtask : rdc
	task automatic cfg(input int c, input logic [31:0] ctl, input logic [31:0] n);
		apb(1'b1, ra(c, OFS_PBASE), pb(c));
		apb(1'b1, ra(c, OFS_MBASE), mb(c));
		apb(1'b1, ra(c, OFS_COUNT), n);
		apb(1'b1, ra(c, OFS_CTRL), ctl);
	endtask : cfg
	task automatic fire_ch(input int c);
		repeat (10) @(posedge core_clk_i);
		fire[c] <= 1'b1;
		@(posedge core_clk_i);
		fire <= '0;
	endtask : fire_ch
	task automatic beat(input logic w, output logic [31:0] a, output logic [31:0] d,
		output logic [1:0] s);
		int n;
		for (n = 0; n < 300; n++) begin
			@(posedge core_clk_i);
			if (bus_valid === 1'b1 && bus_ready === 1'b1 && bus_write === w) break;
		end
		a = bus_addr;
		d = bus_wdata;
		s = bus_size;
		if (n == 300) begin
			miscompares++;
			test_done();
		end
	endtask : beat
	task automatic chk_item(input logic [31:0] ra_x, input logic [31:0] wa_x,
		input logic [31:0] wd_x, input logic [1:0] ws_x);
		logic [31:0] a, d;
		logic [1:0] s;
		beat(1'b0, a, d, s);
		`CHK(a, ra_x)
		beat(1'b1, a, d, s);
		`CHK(a, wa_x)
		`CHK(d, wd_x)
		`CHK(s, ws_x)
	endtask : chk_item
	task automatic idle(input int n);
		int k = 0;
		repeat (n) begin
			@(posedge core_clk_i);
			if (bus_valid !== 1'b0) k++;
		end
		`CHK(k, 0)
	endtask : idle
	initial begin
		core_clk_i = 1'b0;
		rst_i = 1'b1;
		{psel, penable, pwrite, paddr, pwdata, fire, wait_c} = '0;
		repeat (16) @(posedge core_clk_i);
		rst_i <= 1'b0;
		rdc(ra(0, OFS_CTRL), CTRL_RST);
		rdc(ra(3, OFS_COUNT), 32'(CNT_RST));
		apb(1'b0, 12'h100, 32'h0);
		`CHK(e, 1'b1)
		cfg(3, 32'h00000887, 32'd4);
		for (i = 0; i < 4; i++) begin
			fire_ch(3);
			chk_item(pb(3), mb(3) + 32'(4 * i), b8(pb(3)), W_WORD);
			`CHK(dack[3], 1'b1)
			if (i == 1) rdc(OFS_FLAGS, 32'h40);
			if (i == 1) rdc(ra(3, OFS_COUNT), 32'd2);
		end
		`CHK(irq[3], 1'b1)
		rdc(OFS_FLAGS, 32'hc0);
		fire_ch(3);
		idle(40);
		rdc(ra(3, OFS_PBASE), pb(3));
		apb(1'b1, OFS_FLAGS, 32'hc0);
		rdc(OFS_FLAGS, 32'h0);
		`CHK(irq, 8'h00)
		apb(1'b1, ra(3, OFS_COUNT), 32'd5);
		rdc(ra(3, OFS_COUNT), 32'd0);
		apb(1'b1, ra(3, OFS_CTRL), 32'h00000886);
		rdc(ra(3, OFS_CTRL), 32'h00000886);
		apb(1'b1, ra(3, OFS_COUNT), 32'd5);
		rdc(ra(3, OFS_COUNT), 32'd5);
		// same level on 2 and 4, higher level and memory-to-peripheral on 5
		cfg(2, 32'h00001001, 32'd1);
		cfg(4, 32'h00001001, 32'd1);
		cfg(5, 32'h00003011, 32'd1);
		apb(1'b1, OFS_SWTRIG, 32'h34);
		chk_item(mb(5), pb(5), b8(mb(5)), W_BYTE);
		chk_item(pb(2), mb(2), b8(pb(2)), W_BYTE);
		chk_item(pb(4), mb(4), b8(pb(4)), W_BYTE);
		wait_c <= 4'h2;
		cfg(1, 32'h000001e1, 32'd2);
		for (i = 0; i < 3; i++) begin
			fire_ch(1);
			chk_item(pb(1) + 32'(2 * (i % 2)), mb(1) + 32'(i % 2),
				b8(pb(1) + 32'(2 * (i % 2))), W_BYTE);
		end
		rdc(ra(1, OFS_COUNT), 32'd1);
		cfg(6, 32'h00004ac1, 32'd3);
		for (i = 0; i < 3; i++) begin
			chk_item(pb(6) + 32'(4 * i), mb(6) + 32'(4 * i), (pb(6) + 32'(4 * i)) ^ PAT, W_WORD);
		end
		idle(30);
		rdc(ra(6, OFS_COUNT), 32'd0);
		test_done();
	end
endmodule : multichannel_dma_controller_test
`default_nettype wire
